/* hw/pvcr_regs.sv */
// pvcr_regs: vendor configuration registers 18..20 of the 10/100 PHY
// and the control levels they drive into the PHY sub-blocks.
// assumes a management master on clk, one strobe per cycle, and
// status inputs already synchronous to clk.
`timescale 1ns/1ps

module pvcr_regs
  import pvcr_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [PVCR_AW-1:0]  reg_addr,
  input  wire logic [PVCR_DW-1:0]  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [PVCR_DW-1:0]  reg_rdata,
  input  wire logic                speed_10,
  input  wire logic                full_duplex,
  input  wire logic                tp_loopback,
  input  wire logic                polarity_rev_in,
  input  wire logic                auto_crossover_in,
  input  wire logic                sd_raw,
  output logic                     link_pulse_tx_en,
  output logic                     link_good_force,
  output logic                     heartbeat_on,
  output logic                     squelch_normal,
  output logic                     jabber_on,
  output logic      [PVCR_NPD-1:0] pd_sub_block,
  output logic                     sd_good,
  output logic                     autoneg_full_power,
  output logic                     ten_meg_tx_power_save,
  output logic                     crossover_state,
  output logic                     autoneg_loopback_test,
  output logic      [2:0]          test_select,
  output logic      [1:0]          monitor_select
);

  // ************************************
  // state
  // ************************************
  pvcr_state_s s_q;
  pvcr_state_s s_d;

  function automatic logic hit(input logic [PVCR_AW-1:0] a,
                               input logic [PVCR_AW-1:0] r);
    hit = (a == r);
  endfunction : hit

  logic [PVCR_DW-1:0] rd_tenbase;
  logic [PVCR_DW-1:0] rd_speccfg;

  // read-only bits are merged at read time only
  assign rd_tenbase = (s_q.tenbase & PVCR_WM_TENBASE)
                    | {15'h0000, s_q.pol_rev};
  assign rd_speccfg = (s_q.speccfg & PVCR_WM_SPECCFG)
                    | ({15'h0000, s_q.xover} << PVCR_B_XST);

  always_comb begin
    s_d       = s_q;
    s_d.pol_rev = polarity_rev_in;
    // manual value only while override set, else auto decision
    s_d.xover = s_q.speccfg[PVCR_B_XOVR] ? s_q.speccfg[PVCR_B_XVAL]
                                         : auto_crossover_in;
    s_d.rdata = 16'h0000;
    if (reg_wr) begin
      if (hit(reg_addr, PVCR_A_TENBASE)) begin
        s_d.tenbase = reg_wdata & PVCR_WM_TENBASE;
      end
      if (hit(reg_addr, PVCR_A_PDTEST)) begin
        s_d.pdtest = reg_wdata & PVCR_WM_PDTEST;
      end
      if (hit(reg_addr, PVCR_A_SPECCFG)) begin
        s_d.speccfg = reg_wdata & PVCR_WM_SPECCFG;
      end
    end
    // unmapped numbers read as zero
    if (reg_rd) begin
      if (hit(reg_addr, PVCR_A_TENBASE)) begin
        s_d.rdata = rd_tenbase;
      end else if (hit(reg_addr, PVCR_A_PDTEST)) begin
        s_d.rdata = s_q.pdtest & PVCR_WM_PDTEST;
      end else if (hit(reg_addr, PVCR_A_SPECCFG)) begin
        s_d.rdata = rd_speccfg;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.tenbase <= PVCR_RV_TENBASE;
      s_q.pdtest  <= PVCR_RV_PDTEST;
      s_q.speccfg <= PVCR_RV_SPECCFG;
      s_q.pol_rev <= 1'b0;
      s_q.xover   <= 1'b0;
      s_q.rdata   <= 16'h0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;

  // ************************************
  // control levels to the PHY
  // ************************************
  // link pulse control only means something at 10M
  assign link_pulse_tx_en = speed_10 &  s_q.tenbase[PVCR_B_LPEN];
  assign link_good_force  = speed_10 & ~s_q.tenbase[PVCR_B_LPEN];
  // no collision test in full duplex, so the bit is moot there
  assign heartbeat_on = ~full_duplex & s_q.tenbase[PVCR_B_HBEAT];
  assign squelch_normal = s_q.tenbase[PVCR_B_SQL];
  // outside the two modes jabber stays on
  assign jabber_on = (speed_10 & (full_duplex | tp_loopback))
                   ? s_q.tenbase[PVCR_B_JAB] : 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < PVCR_NPD; gi++) begin : g_pd
      assign pd_sub_block[gi] = s_q.pdtest[gi]
                              & s_q.speccfg[PVCR_B_PDLV];
    end
  endgenerate

  assign sd_good               = sd_raw | s_q.speccfg[PVCR_B_FSD];
  assign autoneg_full_power    = s_q.speccfg[PVCR_B_ANFP];
  assign ten_meg_tx_power_save = speed_10 & s_q.speccfg[PVCR_B_TXPS];
  assign crossover_state       = s_q.xover;
  assign autoneg_loopback_test = s_q.speccfg[PVCR_B_ANLB];
  assign test_select    = {s_q.speccfg[PVCR_B_TSA], s_q.speccfg[PVCR_B_TSB],
                           s_q.speccfg[PVCR_B_TSC]};
  assign monitor_select = {s_q.speccfg[PVCR_B_MON1],
                           s_q.speccfg[PVCR_B_MON0]};

  // ************************************
  // checks
  // ************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wr_spec_ovr;
    reg_wr && hit(reg_addr, PVCR_A_SPECCFG) && reg_wdata[PVCR_B_XOVR];
  endsequence

  sequence s_no_spec_wr;
    !(reg_wr && hit(reg_addr, PVCR_A_SPECCFG));
  endsequence

  sequence s_rd_tenbase;
    reg_rd && hit(reg_addr, PVCR_A_TENBASE);
  endsequence

  sequence s_wr_tenbase;
    reg_wr && hit(reg_addr, PVCR_A_TENBASE);
  endsequence

  sequence s_wr_pdtest;
    reg_wr && hit(reg_addr, PVCR_A_PDTEST);
  endsequence

  sequence s_rd_pdtest;
    reg_rd && hit(reg_addr, PVCR_A_PDTEST);
  endsequence

  sequence s_wr_spec;
    reg_wr && hit(reg_addr, PVCR_A_SPECCFG);
  endsequence

  sequence s_rd_spec;
    reg_rd && hit(reg_addr, PVCR_A_SPECCFG);
  endsequence

  sequence s_wr_unmapped;
    reg_wr && !hit(reg_addr, PVCR_A_TENBASE) && !hit(reg_addr, PVCR_A_PDTEST)
      && !hit(reg_addr, PVCR_A_SPECCFG);
  endsequence

  chk_lp_force_good: assert property (
    (speed_10 && !s_q.tenbase[PVCR_B_LPEN]) |->
      (link_good_force && !link_pulse_tx_en))
    else $error("link pulse disable did not force good link");

  chk_hb_fdx_off: assert property (
    full_duplex |-> !heartbeat_on)
    else $error("heartbeat active in full duplex");

  chk_ro_zero_read: assert property (
    s_rd_tenbase |=> (reg_rdata[15] == 1'b0 && reg_rdata[9:1] == 9'h000))
    else $error("reserved bits of register 18 not zero");

  chk_pol_to_read: assert property (
    (polarity_rev_in ##1 s_rd_tenbase) |=> reg_rdata[PVCR_B_POLREV])
    else $error("polarity flag not seen on read");

  chk_pd_write_back: assert property (
    (reg_wr && hit(reg_addr, PVCR_A_PDTEST)) |=>
      (s_q.pdtest == ($past(reg_wdata) & PVCR_WM_PDTEST)))
    else $error("power-down selects not stored");

  chk_pd_level_low: assert property (
    (reg_wr && hit(reg_addr, PVCR_A_SPECCFG) && !reg_wdata[PVCR_B_PDLV])
      |=> (pd_sub_block == 9'h000))
    else $error("sub-block powered down with level zero");

  chk_sd_forced: assert property (
    s_q.speccfg[PVCR_B_FSD] |-> sd_good)
    else $error("signal detect not forced good");

  chk_xover_manual: assert property (
    (s_wr_spec_ovr ##1 s_no_spec_wr) |=>
      (crossover_state == $past(reg_wdata[PVCR_B_XVAL], 2)))
    else $error("manual crossover value not applied");

  chk_ro_keep_zero: assert property (
    (reg_wr && hit(reg_addr, PVCR_A_TENBASE)) |=>
      ((s_q.tenbase & ~PVCR_WM_TENBASE) == 16'h0000))
    else $error("read-only field of register 18 written");

  chk_unmapped_zero: assert property (
    (reg_rd && !hit(reg_addr, PVCR_A_TENBASE) && !hit(reg_addr, PVCR_A_PDTEST)
      && !hit(reg_addr, PVCR_A_SPECCFG)) |=> (reg_rdata == 16'h0000))
    else $error("unmapped read not zero");

  // ************************************
  // control level checks
  // ************************************

  chk_lp_pulse_on: assert property (
    (speed_10 && s_q.tenbase[PVCR_B_LPEN]) |->
      (link_pulse_tx_en && !link_good_force))
    else $error("link pulses not enabled at 10M");

  chk_lp_not_ten: assert property (
    !speed_10 |->
      (!link_pulse_tx_en && !link_good_force && !ten_meg_tx_power_save))
    else $error("10M-only control active outside 10M");

  chk_hb_hdx_follow: assert property (
    (s_wr_tenbase ##1 !full_duplex) |->
      (heartbeat_on == $past(reg_wdata[PVCR_B_HBEAT])))
    else $error("heartbeat enable not applied in half duplex");

  chk_jab_gated: assert property (
    (s_wr_tenbase ##1 (speed_10 && (full_duplex || tp_loopback))) |->
      (jabber_on == $past(reg_wdata[PVCR_B_JAB])))
    else $error("jabber enable not applied in its modes");

  chk_jab_outside: assert property (
    !(speed_10 && (full_duplex || tp_loopback)) |-> jabber_on)
    else $error("jabber gated outside its modes");

  chk_pd_level_high: assert property (
    s_q.speccfg[PVCR_B_PDLV] |->
      (pd_sub_block == s_q.pdtest[PVCR_NPD-1:0]))
    else $error("selected sub-block not powered down");

  chk_sd_normal: assert property (
    !s_q.speccfg[PVCR_B_FSD] |-> (sd_good == sd_raw))
    else $error("signal detect forced while not selected");

  chk_anfp_write: assert property (
    s_wr_spec |=>
      (autoneg_full_power == $past(reg_wdata[PVCR_B_ANFP])))
    else $error("autoneg power mode not applied");

  chk_txps_write: assert property (
    (s_wr_spec ##1 speed_10) |->
      (ten_meg_tx_power_save == $past(reg_wdata[PVCR_B_TXPS])))
    else $error("10M transmit power mode not applied");

  chk_xover_auto: assert property (
    !s_q.speccfg[PVCR_B_XOVR] |=>
      (crossover_state == $past(auto_crossover_in)))
    else $error("automatic crossover not followed");

  chk_anlb_write: assert property (
    s_wr_spec |=>
      (autoneg_loopback_test == $past(reg_wdata[PVCR_B_ANLB])))
    else $error("autoneg loopback select not applied");

  chk_tsel_write: assert property (
    s_wr_spec |=>
      ((test_select == {$past(reg_wdata[PVCR_B_TSA]), $past(reg_wdata[PVCR_B_TSB]),
                        $past(reg_wdata[PVCR_B_TSC])})
       && (monitor_select == {$past(reg_wdata[PVCR_B_MON1]), $past(reg_wdata[PVCR_B_MON0])})))
    else $error("test or monitor selects not applied");

  // ************************************
  // read path and unmapped write checks
  // ************************************

  chk_pd_ro_read: assert property (
    s_rd_pdtest |=> (reg_rdata[15:9] == 7'h00))
    else $error("reserved bits of register 19 not zero");

  chk_pd_read_back: assert property (
    (s_wr_pdtest ##1 s_rd_pdtest) |=>
      (reg_rdata == ($past(reg_wdata, 2) & PVCR_WM_PDTEST)))
    else $error("power-down selects not read back");

  chk_pol_clear: assert property (
    (!polarity_rev_in ##1 s_rd_tenbase) |=> !reg_rdata[PVCR_B_POLREV])
    else $error("polarity flag set with normal polarity");

  chk_xst_read: assert property (
    s_rd_spec |=>
      (reg_rdata[PVCR_B_XST] == $past(crossover_state)))
    else $error("crossover status read differs from state");

  chk_rdata_idle: assert property (
    !reg_rd |=> (reg_rdata == 16'h0000))
    else $error("read data not zero outside read cycle");

  chk_unmapped_wr: assert property (
    s_wr_unmapped |=>
      ($stable(s_q.tenbase) && $stable(s_q.pdtest) && $stable(s_q.speccfg)))
    else $error("unmapped write changed a register");

  chk_spec_read_back: assert property (
    (s_wr_spec ##1 s_rd_spec) |=>
      ((reg_rdata & PVCR_WM_SPECCFG) == ($past(reg_wdata, 2) & PVCR_WM_SPECCFG)))
    else $error("register 20 writable bits not read back");

  chk_ten_read_back: assert property (
    (s_wr_tenbase ##1 s_rd_tenbase) |=>
      ((reg_rdata & PVCR_WM_TENBASE) == ($past(reg_wdata, 2) & PVCR_WM_TENBASE)))
    else $error("register 18 writable bits not read back");

endmodule : pvcr_regs

/* pkg/pvcr_pkg.sv */
// pvcr_pkg: addresses, field positions, masks and reset values
// for the PHY vendor configuration registers 18 to 20.
// assumes a 5-bit management register number and 16-bit words.
package pvcr_pkg;

  localparam int          PVCR_AW         = 5;
  localparam int          PVCR_DW         = 16;
  localparam int          PVCR_NPD        = 9;

  // ************************************
  // register numbers
  // ************************************
  localparam logic [4:0]  PVCR_A_TENBASE  = 5'h12;
  localparam logic [4:0]  PVCR_A_PDTEST   = 5'h13;
  localparam logic [4:0]  PVCR_A_SPECCFG  = 5'h14;

  // ************************************
  // tenbase_config_status fields
  // ************************************
  localparam int          PVCR_B_LPEN     = 14;
  localparam int          PVCR_B_HBEAT    = 13;
  localparam int          PVCR_B_SQL      = 12;
  localparam int          PVCR_B_JAB      = 11;
  localparam int          PVCR_B_POLREV   = 0;

  // ************************************
  // specified_config fields
  // ************************************
  localparam int          PVCR_B_TSA      = 15;
  localparam int          PVCR_B_TSB      = 14;
  localparam int          PVCR_B_FSD      = 13;
  localparam int          PVCR_B_TSC      = 12;
  localparam int          PVCR_B_ANFP     = 11;
  localparam int          PVCR_B_TXPS     = 10;
  localparam int          PVCR_B_XST      = 7;
  localparam int          PVCR_B_ANLB     = 6;
  localparam int          PVCR_B_XVAL     = 5;
  localparam int          PVCR_B_XOVR     = 4;
  localparam int          PVCR_B_MON1     = 3;
  localparam int          PVCR_B_MON0     = 2;
  localparam int          PVCR_B_PDLV     = 0;

  // ************************************
  // writable masks and reset values
  // ************************************
  localparam logic [15:0] PVCR_WM_TENBASE = 16'h7C00;
  localparam logic [15:0] PVCR_WM_PDTEST  = 16'h01FF;
  localparam logic [15:0] PVCR_WM_SPECCFG = 16'hFF7F;
  localparam logic [15:0] PVCR_RV_TENBASE = 16'h7800;
  localparam logic [15:0] PVCR_RV_PDTEST  = 16'h0000;
  localparam logic [15:0] PVCR_RV_SPECCFG = 16'h0000;

  typedef struct packed {
    logic [15:0] tenbase;
    logic [15:0] pdtest;
    logic [15:0] speccfg;
    logic        pol_rev;
    logic        xover;
    logic [15:0] rdata;
  } pvcr_state_s;

endpackage : pvcr_pkg

/* verif/pvcr_mgmt_model.sv */
// pvcr_mgmt_model: station management master on the MAC side.
// assumes the register port of pvcr_regs on the same clk.
`timescale 1ns/1ps

module pvcr_mgmt_model
  import pvcr_pkg::*;
(
  input  wire logic               clk,
  input  wire logic [PVCR_DW-1:0] reg_rdata,
  output logic      [PVCR_AW-1:0] reg_addr,
  output logic      [PVCR_DW-1:0] reg_wdata,
  output logic                    reg_wr,
  output logic                    reg_rd
);
  initial begin
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // strobe left high; the following read lowers it
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d & ~((a == PVCR_A_TENBASE) ? 16'h0400 : (a == PVCR_A_SPECCFG) ? 16'h0002 : 16'h0000);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= ~reg_wdata;
    @(posedge clk);
    reg_rd <= 1'b0;
    // data stand in the cycle after the strobe; taken at its closing edge
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : pvcr_mgmt_model

/* verif/phy_vendor_config_regs_tb.sv */
// phy_vendor_config_regs_tb: random register traffic against a bench model.
// assumes pvcr_regs and pvcr_mgmt_model, one 100 MHz clock.
`timescale 1ns/1ps

module phy_vendor_config_regs_tb
  import pvcr_pkg::*;
;
  logic clk, rst, spd, fd, lb, pol, ax, sd;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd;
  logic link_pulse_tx_en, link_good_force, heartbeat_on, squelch_normal, jabber_on;
  logic sd_good, autoneg_full_power, ten_meg_tx_power_save, crossover_state, autoneg_loopback_test;
  logic [8:0] pd_sub_block;
  logic [2:0] test_select;
  logic [1:0] monitor_select;
  logic [15:0] m [3];
  localparam logic [15:0] WM [3] = '{PVCR_WM_TENBASE, PVCR_WM_PDTEST, PVCR_WM_SPECCFG};
  int n_mismatch, total_checks;

  pvcr_regs dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .speed_10(spd), .full_duplex(fd), .tp_loopback(lb), .polarity_rev_in(pol),
    .auto_crossover_in(ax), .sd_raw(sd), .link_pulse_tx_en, .link_good_force, .heartbeat_on,
    .squelch_normal, .jabber_on, .pd_sub_block, .sd_good, .autoneg_full_power,
    .ten_meg_tx_power_save, .crossover_state, .autoneg_loopback_test, .test_select, .monitor_select);
  pvcr_mgmt_model mgr (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] exp_rd(int k);
    if (k == 0) return m[0] | {15'h0000, pol};
    if (k == 2) return m[2] | {8'h00, (m[2][4] ? m[2][5] : ax), 7'h00};
    return m[1];
  endfunction : exp_rd

  function automatic logic [31:0] exp_out();
    logic [15:0] t, p, s;
    t = m[0];
    p = m[1];
    s = m[2];
    return {8'h00, spd & t[14], spd & ~t[14], t[13] & ~fd, t[12], (spd & (fd | lb)) ? t[11] : 1'b1,
      p[8:0] & {9{s[0]}}, sd | s[13], s[11], spd & s[10], s[4] ? s[5] : ax, s[6], s[15], s[14], s[12], s[3], s[2]};
  endfunction : exp_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // far beyond the roughly 700 cycles the sequence needs
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end

  initial begin
    logic [15:0] d;
    logic [4:0]  a;
    int          i;
    i = $urandom(53);
    rst = 1'b1;
    {spd, fd, lb, pol, ax, sd} = 6'h00;
    m = '{PVCR_RV_TENBASE, PVCR_RV_PDTEST, PVCR_RV_SPECCFG};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      mgr.rd(PVCR_A_TENBASE + 5'(k), d);
      check({16'h0000, d}, {16'h0000, exp_rd(k)});
    end
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      {spd, fd, lb, pol, ax, sd} <= 6'($urandom);
      i = $urandom_range(3, 0);
      a = (i == 3) ? 5'h15 + 5'($urandom_range(10, 0)) : PVCR_A_TENBASE + 5'(i);
      d = 16'($urandom);
      mgr.wr(a, d);
      if (i < 3) begin
        d = d & ~((i == 0) ? 16'h0400 : (i == 2) ? 16'h0002 : 16'h0000);
        m[i] = (m[i] & ~WM[i]) | (d & WM[i]);
      end
      // back-to-back read of the word just written
      mgr.rd(a, d);
      if (i == 3) check({16'h0000, d}, 32'h0000_0000);
      else check({16'h0000, d & WM[i]}, {16'h0000, m[i] & WM[i]});
      repeat (3) @(posedge clk);
      for (int k = 0; k < 3; k++) begin
        mgr.rd(PVCR_A_TENBASE + 5'(k), d);
        check({16'h0000, d}, {16'h0000, exp_rd(k)});
      end
      check({8'h00, link_pulse_tx_en, link_good_force, heartbeat_on, squelch_normal, jabber_on, pd_sub_block,
        sd_good, autoneg_full_power, ten_meg_tx_power_save, crossover_state, autoneg_loopback_test,
        test_select, monitor_select}, exp_out());
    end
    // mid-run reset: every written field must fall back to its reset value
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    m = '{PVCR_RV_TENBASE, PVCR_RV_PDTEST, PVCR_RV_SPECCFG};
    for (int k = 0; k < 3; k++) begin
      mgr.rd(PVCR_A_TENBASE + 5'(k), d);
      check({16'h0000, d}, {16'h0000, exp_rd(k)});
    end
    summarize();
  end
endmodule : phy_vendor_config_regs_tb
